// ===== src/awp_top.sv
// arbitrary waveform playback engine with a classic wishbone register slave
`timescale 1ns/1ps
`include "awp_consts.svh"
module awp_top #(
  parameter int NUM_CH = 8,
  parameter int DEPTH = 1024,
  parameter int SAMP_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [NUM_CH*SAMP_W-1:0] dac_out,
  output logic dac_load,
  output logic play_active,
  output awp_pkg::awp_err_type err_flags
);
  import awp_pkg::*;

  localparam int CH_W = $clog2(NUM_CH);
  localparam int IX_W = $clog2(DEPTH);
  localparam int AW = CH_W + IX_W;
  localparam int REF_DIV = `AWP_CLK_HZ / `AWP_REF_HZ;
  localparam logic [27:0] MAX_TICKS = 28'(`AWP_MAX_SEG_S * `AWP_REF_HZ);
  localparam logic [6:0] REF_LAST = 7'(REF_DIV - 1);
  localparam logic [10:0] DEPTH_V = 11'(DEPTH);
  localparam logic [7:0] NCH_V = 8'(NUM_CH);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic stage_reg, ack_reg;
  logic [31:0] dat_reg;
  logic clr_busy_reg;
  logic [AW-1:0] clr_addr_reg;
  wire req = wb_cyc_i & wb_stb_i;
  // one idle stage gives the sample memory its read cycle
  wire take = req & ~stage_reg & ~ack_reg & ~clr_busy_reg;
  wire wr = ack_reg & wb_we_i & (wb_sel_i == 4'hf);
  wire rd = ack_reg & ~wb_we_i;
  wire hit_ctrl = wb_adr_i == `AWP_OFF_CTRL;
  wire hit_stat = wb_adr_i == `AWP_OFF_STATUS;
  wire hit_pts = wb_adr_i == `AWP_OFF_POINTS;
  wire hit_sdiv = wb_adr_i == `AWP_OFF_SDIV;
  wire hit_rpt = wb_adr_i == `AWP_OFF_RPT;
  wire hit_load = wb_adr_i == `AWP_OFF_LOAD;
  wire hit_data = wb_adr_i == `AWP_OFF_DATA;
  wire hit_pos = wb_adr_i == `AWP_OFF_POS;
  wire hit_segs = wb_adr_i == `AWP_OFF_SEGS;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      stage_reg <= take;
      ack_reg <= stage_reg;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [10:0] points_reg;
  logic [16:0] sdiv_reg;
  logic [21:0] rpt_reg;
  logic [12:0] segs_reg;
  logic rpt_en_reg, tick_mode_reg;
  logic ld_ok_reg;
  logic [CH_W-1:0] ld_ch_reg;
  logic [IX_W-1:0] ld_ix_reg;
  awp_err_type err_reg;

  wire [10:0] pts_val = wb_dat_i[10:0];
  wire [16:0] sdiv_val = wb_dat_i[16:0];
  wire [21:0] rpt_val = wb_dat_i[21:0];
  wire [12:0] segs_val = wb_dat_i[12:0];
  wire [7:0] ld_ch_val = wb_dat_i[7:0];
  wire [10:0] ld_ix_val = wb_dat_i[`AWP_LD_IX_LSB +: 11];
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_pts = wr & hit_pts;
  wire wr_sdiv = wr & hit_sdiv;
  wire wr_rpt = wr & hit_rpt;
  wire wr_load = wr & hit_load;
  wire wr_segs = wr & hit_segs;
  wire pts_ok = wb_dat_i[`AWP_PTS_GIVEN] & (pts_val != 11'h000) & (pts_val <= DEPTH_V);
  // divider range gives 3.662 Hz to 15 kHz
  wire sdiv_ok = (sdiv_val >= `AWP_SDIV_MIN) & (sdiv_val <= `AWP_SDIV_MAX);
  wire rpt_ok = (rpt_val >= `AWP_RPT_MIN) & (rpt_val <= `AWP_RPT_MAX);
  // both load parameters present and legal
  wire ld_ok = wb_dat_i[`AWP_LD_CH_GIVEN] & wb_dat_i[`AWP_LD_IX_GIVEN]
               & (ld_ch_val != 8'h00) & (ld_ch_val <= NCH_V)
               & (ld_ix_val != 11'h000) & (ld_ix_val <= DEPTH_V);
  wire clear_cmd = wr_ctrl & wb_dat_i[`AWP_CTL_CLEAR];
  wire arm_cmd = wr_ctrl & wb_dat_i[`AWP_CTL_ARM];
  wire data_wr = wr & hit_data & ld_ok_reg;
  wire data_rd = rd & hit_data;
  // arm checks must see the mode bits carried by the same ctrl word
  wire rpt_en_now = wr_ctrl ? wb_dat_i[`AWP_CTL_RPTEN] : rpt_en_reg;
  wire tick_mode_now = wr_ctrl ? wb_dat_i[`AWP_CTL_TICKM] : tick_mode_reg;

  wire [27:0] seg_ticks = {17'h00000, points_reg} * {11'h000, sdiv_reg};
  // repeat off makes the interval the segment period
  wire [27:0] interval = rpt_en_reg ? {6'h00, rpt_reg} : seg_ticks;
  wire dur_bad = seg_ticks >= MAX_TICKS;
  // repeat and per-tick trigger exclude each other
  wire mode_bad = rpt_en_now & tick_mode_now;
  wire gap_bad = rpt_en_now & ({6'h00, rpt_reg} < seg_ticks);
  wire arm_go = arm_cmd & ~dur_bad & ~mode_bad & ~gap_bad;

  wire awp_err_type err_set;
  assign err_set[`AWP_ERR_LOAD] = wr_load & ~ld_ok;
  assign err_set[`AWP_ERR_POINTS] = wr_pts & ~pts_ok;
  assign err_set[`AWP_ERR_RATE] = wr_sdiv & ~sdiv_ok;
  assign err_set[`AWP_ERR_RPT] = wr_rpt & ~rpt_ok;
  assign err_set[`AWP_ERR_DUR] = arm_cmd & dur_bad;
  assign err_set[`AWP_ERR_MODE] = arm_cmd & mode_bad;
  assign err_set[`AWP_ERR_GAP] = arm_cmd & gap_bad;
  wire [6:0] err_clr = (wr & hit_stat) ? wb_dat_i[6:0] : 7'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      points_reg <= `AWP_RST_POINTS;
      sdiv_reg <= `AWP_RST_SDIV;
      rpt_reg <= `AWP_RST_RPT;
      segs_reg <= `AWP_RST_SEGS;
      rpt_en_reg <= 1'b0;
      tick_mode_reg <= 1'b0;
      err_reg <= '0;
    end else begin
      // a new error outranks a same-cycle clear
      err_reg <= (err_reg & ~err_clr) | err_set;
      // one shared count, kept by zero-all
      if (wr_pts && pts_ok) begin
        points_reg <= pts_val;
      end
      // the divider n is stored and read back as programmed
      if (wr_sdiv && sdiv_ok) begin
        sdiv_reg <= sdiv_val;
      end
      if (wr_rpt && rpt_ok) begin
        rpt_reg <= rpt_val;
      end
      if (wr_segs && segs_val != 13'h0000 && segs_val <= `AWP_SEGS_MAX) begin
        segs_reg <= segs_val;
      end
      if (wr_ctrl) begin
        rpt_en_reg <= wb_dat_i[`AWP_CTL_RPTEN];
        tick_mode_reg <= wb_dat_i[`AWP_CTL_TICKM];
      end
    end
  end

  // ----------------------------------------------------------------
  // load pointer: channel and index, auto-incrementing
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ld_ok_reg <= 1'b0;
      ld_ch_reg <= '0;
      ld_ix_reg <= '0;
    end else if (wr_load) begin
      ld_ok_reg <= ld_ok;
      if (ld_ok) begin
        ld_ch_reg <= CH_W'(ld_ch_val - 8'h01);
        ld_ix_reg <= IX_W'(ld_ix_val - 11'h001);
      end
    end else if (data_wr || data_rd) begin
      // successive reads walk the channel from the given index
      ld_ix_reg <= ld_ix_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sample memory with clear sweep
  // ----------------------------------------------------------------
  // DEPTH words of SAMP_W bits per channel
  logic [SAMP_W-1:0] mem [NUM_CH*DEPTH];
  logic [SAMP_W-1:0] rd_q_reg, fetch_q_reg;
  logic [CH_W:0] fetch_cnt_reg;
  logic fetch_run_reg;
  logic [10:0] samp_reg;
  wire [AW-1:0] ld_addr = {ld_ch_reg, ld_ix_reg};
  wire [IX_W-1:0] samp_ix = IX_W'(samp_reg - 11'h001);
  wire [AW-1:0] fetch_addr = {fetch_cnt_reg[CH_W-1:0], samp_ix};

  always_ff @(posedge clk) begin
    // sweep writes zero to every word; bus is stalled meanwhile
    if (clr_busy_reg) begin
      mem[clr_addr_reg] <= '0;
    end else if (data_wr) begin
      mem[ld_addr] <= wb_dat_i[SAMP_W-1:0];
    end
    rd_q_reg <= mem[ld_addr];
    fetch_q_reg <= mem[fetch_addr];
  end

  always_ff @(posedge clk) begin
    // reset starts the same sweep as zero-all
    if (rst) begin
      clr_busy_reg <= 1'b1;
      clr_addr_reg <= '0;
    end else if (clear_cmd) begin
      clr_busy_reg <= 1'b1;
      clr_addr_reg <= '0;
    end else if (clr_busy_reg) begin
      clr_addr_reg <= clr_addr_reg + 1'b1;
      if (&clr_addr_reg) begin
        clr_busy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sample clock: 240 kHz reference, then divide by n
  // ----------------------------------------------------------------
  logic [6:0] ref_cnt_reg;
  logic ref_en_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_cnt_reg <= '0;
      ref_en_reg <= 1'b0;
    end else begin
      ref_en_reg <= ref_cnt_reg == REF_LAST;
      ref_cnt_reg <= (ref_cnt_reg == REF_LAST) ? 7'h00 : ref_cnt_reg + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // playback sequencer
  // ----------------------------------------------------------------
  awp_state_type state_reg;
  logic play_reg, fetch_go_reg;
  logic [12:0] seg_reg;
  logic [16:0] tick_reg;
  logic [27:0] per_reg;
  wire seg_end = per_reg == (interval - 28'h0000001);
  wire tick_last = tick_reg == (sdiv_reg - 17'h00001);
  // writes and reads that imply an abort
  wire abort_any = (wr_ctrl & wb_dat_i[`AWP_CTL_ABORT]) | clear_cmd | wr_load
                   | (wr & hit_data) | wr_sdiv | data_rd;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      play_reg <= 1'b0;
      seg_reg <= '0;
      samp_reg <= '0;
      tick_reg <= '0;
      per_reg <= '0;
      fetch_go_reg <= 1'b0;
    end else begin
      fetch_go_reg <= 1'b0;
      if (abort_any) begin
        state_reg <= ST_IDLE;
        play_reg <= 1'b0;
        if (clear_cmd) begin
          seg_reg <= '0;
          samp_reg <= '0;
        end
      end else if (arm_go) begin
        state_reg <= ST_PLAY;
        play_reg <= 1'b1;
        seg_reg <= 13'h0001;
        samp_reg <= 11'h001;
        tick_reg <= '0;
        per_reg <= '0;
        fetch_go_reg <= 1'b1;
      end else if (play_reg && ref_en_reg) begin
        if (seg_end) begin
          // last segment done, hold output and position
          if (seg_reg == segs_reg) begin
            state_reg <= ST_HOLD;
            play_reg <= 1'b0;
          end else begin
            // next segment starts on the same tick as the last sample ends
            seg_reg <= seg_reg + 13'h0001;
            samp_reg <= 11'h001;
            tick_reg <= '0;
            per_reg <= '0;
            fetch_go_reg <= 1'b1;
          end
        end else begin
          per_reg <= per_reg + 28'h0000001;
          if (tick_last) begin
            tick_reg <= '0;
            // advance sample; past the end it holds frozen
            if (samp_reg < points_reg) begin
              samp_reg <= samp_reg + 11'h001;
              fetch_go_reg <= 1'b1;
            end
          end else begin
            tick_reg <= tick_reg + 17'h00001;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // fetch: read all channels then update outputs together
  // ----------------------------------------------------------------
  logic cap_vld_reg, load_pend_reg, load_reg;
  logic [CH_W-1:0] cap_ch_reg;
  logic [NUM_CH*SAMP_W-1:0] shadow_reg, dac_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_run_reg <= 1'b0;
      fetch_cnt_reg <= '0;
      cap_vld_reg <= 1'b0;
      cap_ch_reg <= '0;
      load_pend_reg <= 1'b0;
      load_reg <= 1'b0;
    end else begin
      cap_vld_reg <= fetch_run_reg;
      cap_ch_reg <= fetch_cnt_reg[CH_W-1:0];
      load_pend_reg <= cap_vld_reg & (cap_ch_reg == CH_W'(NUM_CH - 1));
      load_reg <= load_pend_reg & ~clear_cmd;
      if (fetch_go_reg) begin
        fetch_run_reg <= 1'b1;
        fetch_cnt_reg <= '0;
      end else if (fetch_run_reg) begin
        fetch_cnt_reg <= fetch_cnt_reg + 1'b1;
        if (fetch_cnt_reg == (CH_W+1)'(NUM_CH - 1)) begin
          fetch_run_reg <= 1'b0;
        end
      end
    end
  end

  // one tick loads every channel at once
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
      always_ff @(posedge clk) begin
        if (rst) begin
          shadow_reg[gi*SAMP_W +: SAMP_W] <= '0;
          dac_reg[gi*SAMP_W +: SAMP_W] <= '0;
        end else begin
          if (cap_vld_reg && cap_ch_reg == CH_W'(gi)) begin
            shadow_reg[gi*SAMP_W +: SAMP_W] <= fetch_q_reg;
          end
          // zero-all also forces the outputs to zero
          if (clear_cmd) begin
            dac_reg[gi*SAMP_W +: SAMP_W] <= '0;
          end else if (load_pend_reg) begin
            dac_reg[gi*SAMP_W +: SAMP_W] <= shadow_reg[gi*SAMP_W +: SAMP_W];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [31:0] ctrl_rd = {27'h0, tick_mode_reg, rpt_en_reg, 3'h0};
  wire [31:0] stat_rd = {22'h0, clr_busy_reg, play_reg, 1'b0, err_reg};
  // segment in the upper half, sample index in the lower
  wire [31:0] pos_rd = {3'h0, seg_reg, 5'h00, samp_reg};
  wire [31:0] ld_rd = {6'h0, ld_ok_reg, ld_ok_reg, 5'h00, 11'(ld_ix_reg) + 11'h001,
                       8'(ld_ch_reg) + 8'h01};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                       hit_stat ? stat_rd :
                       hit_pts ? {21'h0, points_reg} :
                       hit_sdiv ? {15'h0, sdiv_reg} :
                       hit_rpt ? {10'h0, rpt_reg} :
                       hit_load ? ld_rd :
                       hit_data ? 32'(rd_q_reg) :
                       hit_pos ? pos_rd :
                       hit_segs ? {19'h0, segs_reg} : 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (rst) begin
      dat_reg <= '0;
    end else if (stage_reg) begin
      dat_reg <= wb_we_i ? 32'h0000_0000 : rd_mux;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign dac_out = dac_reg;
  assign dac_load = load_reg;
  assign play_active = play_reg;
  assign err_flags = err_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_load_missing;
    @(posedge clk) disable iff (rst)
    (wr_load && !wb_dat_i[`AWP_LD_IX_GIVEN]) |=> err_reg[`AWP_ERR_LOAD] && !ld_ok_reg;
  endproperty
  a_load_missing: assert property (p_load_missing) else $error("load w/o index no error");

  property p_load_abort;
    @(posedge clk) disable iff (rst)
    (play_reg && wr_load) |=> !play_reg ##1 (state_reg == ST_IDLE);
  endproperty
  a_load_abort: assert property (p_load_abort) else $error("load did not abort");

  property p_points_bad;
    @(posedge clk) disable iff (rst)
    (wr_pts && pts_val == 11'h000) |=> $stable(points_reg) && err_reg[`AWP_ERR_POINTS];
  endproperty
  a_points_bad: assert property (p_points_bad) else $error("bad points accepted");

  property p_dur;
    @(posedge clk) disable iff (rst)
    (arm_cmd && dur_bad && !abort_any) |=> err_reg[`AWP_ERR_DUR] && state_reg != ST_PLAY;
  endproperty
  a_dur: assert property (p_dur) else $error("too long segment armed");

  property p_mode;
    @(posedge clk) disable iff (rst)
    (arm_cmd && wb_dat_i[`AWP_CTL_RPTEN] && wb_dat_i[`AWP_CTL_TICKM])
      |=> err_reg[`AWP_ERR_MODE];
  endproperty
  a_mode: assert property (p_mode) else $error("repeat with tick mode not flagged");

  property p_gap;
    @(posedge clk) disable iff (rst)
    (arm_cmd && wb_dat_i[`AWP_CTL_RPTEN] && {6'h00, rpt_reg} < seg_ticks)
      |=> err_reg[`AWP_ERR_GAP];
  endproperty
  a_gap: assert property (p_gap) else $error("short interval not flagged");

  property p_rate_abort;
    @(posedge clk) disable iff (rst)
    (play_reg && wr_sdiv) |=> !play_reg [*3];
  endproperty
  a_rate_abort: assert property (p_rate_abort) else $error("rate change kept playing");

  property p_hold;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_HOLD && !abort_any && !arm_cmd) |=> $stable(seg_reg) && $stable(samp_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("position moved while holding");

  property p_freeze;
    @(posedge clk) disable iff (rst)
    (play_reg && ref_en_reg && !seg_end && samp_reg == points_reg && !abort_any && !arm_cmd)
      |=> $stable(samp_reg) && $stable(seg_reg) && !fetch_go_reg;
  endproperty
  a_freeze: assert property (p_freeze) else $error("position moved in gap");

  property p_clear;
    @(posedge clk) disable iff (rst)
    clear_cmd |=> !play_reg && clr_busy_reg && dac_reg == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("zero-all did not stop output");
endmodule : awp_top

// ===== src/awp_consts.svh
// register map, field positions, reset values and timing for the waveform player
// Overview of operation
// - a sample load without channel or start index flags an error, memory untouched
// - a sample load during playback aborts, then loads; playback waits for a new arm
// - each channel holds at most 1024 sixteen-bit samples, 2048 bytes
// - one points count is shared by all eight channels
// - a points write with no value or out of range raises an error
// - arming checks points times sample period below 16 seconds, else error
// - repeat rate is the inverse of repeat interval; off means interval equals segment
// - repeat enabled with per-tick trigger mode gives an error at arming
// - interval longer than segment holds the last sample until the next segment
// - interval equal to segment plays the next first sample with no gap
// - interval shorter than segment gives an error at arming
// - segment period is the sample period times the points count
// - one sample clock paces all eight channels
// - sample rate 3.662 Hz to 15e3 Hz, quantized, readback gives quantized value
// - a sample rate change during playback aborts and waits idle for a new arm
// - a sample readback during playback aborts, then returns the data
// - readback returns listed positions or every stored value of a channel
// - a position read returns current segment and sample index
// - after the sequence ends the last sample and final position are held
// - during a repeat gap segment and sample positions stay frozen
// - rates are 240000/n and intervals n/240000; readback gives programmed n
// - the zero-all command zeroes every sample of all eight channels
// - reset clears memory, position goes to zero, no output until loaded and armed
// - a zero-all command during playback stops output at once; a sample fetch already under way still reloads dac_out when it completes
// - the zero-all command keeps the points count
`ifndef AWP_CONSTS_SVH
`define AWP_CONSTS_SVH
`define AWP_OFF_CTRL 8'h00
`define AWP_OFF_STATUS 8'h04
`define AWP_OFF_POINTS 8'h08
`define AWP_OFF_SDIV 8'h0c
`define AWP_OFF_RPT 8'h10
`define AWP_OFF_LOAD 8'h14
`define AWP_OFF_DATA 8'h18
`define AWP_OFF_POS 8'h1c
`define AWP_OFF_SEGS 8'h20
`define AWP_CTL_ARM 0
`define AWP_CTL_ABORT 1
`define AWP_CTL_CLEAR 2
`define AWP_CTL_RPTEN 3
`define AWP_CTL_TICKM 4
`define AWP_PTS_GIVEN 31
`define AWP_LD_IX_LSB 8
`define AWP_LD_CH_GIVEN 24
`define AWP_LD_IX_GIVEN 25
`define AWP_ERR_LOAD 0
`define AWP_ERR_POINTS 1
`define AWP_ERR_RATE 2
`define AWP_ERR_RPT 3
`define AWP_ERR_DUR 4
`define AWP_ERR_MODE 5
`define AWP_ERR_GAP 6
`define AWP_RST_POINTS 11'h001
`define AWP_RST_SDIV 17'h00010
`define AWP_RST_RPT 22'h000010
`define AWP_RST_SEGS 13'h0001
`define AWP_SDIV_MIN 17'h00010
`define AWP_SDIV_MAX 17'h10000
`define AWP_RPT_MIN 22'h000010
`define AWP_RPT_MAX 22'h3a9800
`define AWP_SEGS_MAX 13'h1000
`define AWP_CLK_HZ 25000000
`define AWP_REF_HZ 240000
`define AWP_MAX_SEG_S 16
`endif

// ===== src/awp_pkg.sv
// types shared by the waveform player
package awp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_PLAY, ST_HOLD} awp_state_type;
  typedef logic [6:0] awp_err_type;
endpackage : awp_pkg

// ===== sim/awp_dac_model.sv
// capture model of the converter bank that the player feeds
`timescale 1ns/1ps
module awp_dac_model #(
  parameter int NUM_CH = 8
) (
  input wire logic clk,
  input wire logic [NUM_CH*16-1:0] dac_out,
  input wire logic dac_load,
  output logic [15:0] ch0_word,
  output int load_count
);
  always @(posedge clk) begin
    if (dac_load === 1'b1) begin
      ch0_word <= dac_out[15:0];
      load_count <= load_count + 1;
    end
  end
endmodule : awp_dac_model

// ===== sim/arb_waveform_playback_tb.sv
// self-checking bench for the waveform player, driven over wishbone
`timescale 1ns/1ps
module arb_waveform_playback_tb;
  logic clk = 0;
  logic rst = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic [127:0] dac_out;
  logic dac_load;
  logic play_active;
  awp_pkg::awp_err_type err_flags;
  logic [15:0] ch0_word;
  int load_count;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] rd;

  always #20 clk = ~clk;

  awp_top dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .dac_out(dac_out), .dac_load(dac_load), .play_active(play_active),
    .err_flags(err_flags));
  awp_dac_model dac (.clk(clk), .dac_out(dac_out), .dac_load(dac_load),
    .ch0_word(ch0_word), .load_count(load_count));

  // --------------------------------
  // bus and compare tasks
  // --------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  // one classic cycle; the ack wait covers the clear sweep as well
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20000);
    rd = dat_o;
    chk("ack", 32'h1, {31'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    wb(a, 1'b0, 32'h0);
    chk(nm, exp, rd);
  endtask : rdchk

  // compares the sticky error bits, then clears them
  task errchk(input logic [6:0] exp);
    wb(8'h04, 1'b0, 32'h0);
    chk("err", {25'h0, exp}, {25'h0, rd[6:0]});
    chk("err_flags", {25'h0, exp}, {25'h0, err_flags});
    wr(8'h04, 32'h7f);
  endtask : errchk

  task wait_play(input logic v);
    int n;
    n = 0;
    while (play_active !== v && n < 30000) begin
      @(posedge clk);
      n++;
    end
    chk("play_active", {31'h0, v}, {31'h0, play_active});
  endtask : wait_play

  task wait_load;
    int n;
    int c;
    n = 0;
    c = load_count;
    while (load_count == c && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk("load_seen", 32'h1, {31'h0, load_count != c});
  endtask : wait_load

  task finish_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // --------------------------------
  // scenarios
  // --------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'h08, 32'h1, "points");
    rdchk(8'h0c, 32'h10, "sdiv");
    rdchk(8'h1c, 32'h0, "pos");
    wr(8'h14, 32'h0000_0101);
    errchk(7'h01);
    wr(8'h08, 32'h0000_0002);
    wr(8'h08, 32'h8000_0401);
    errchk(7'h02);
    rdchk(8'h08, 32'h1, "points");
    wr(8'h0c, 32'h0f);
    errchk(7'h04);
    wr(8'h08, 32'h8000_0400);
    wr(8'h0c, 32'h1_0000);
    wr(8'h00, 32'h1);
    errchk(7'h10);
    wr(8'h0c, 32'h10);
    wr(8'h08, 32'h8000_0002);
    wr(8'h10, 32'h10);
    wr(8'h00, 32'h09);
    errchk(7'h40);
    wr(8'h10, 32'h20);
    wr(8'h00, 32'h19);
    errchk(7'h20);
    wr(8'h00, 32'h09);
    errchk(7'h00);
    wait_play(1'b1);
    wr(8'h14, 32'h0300_0101);
    wait_play(1'b0);
    wr(8'h00, 32'h0);
    wr(8'h18, 32'h1234);
    wr(8'h18, 32'h5678);
    wr(8'h14, 32'h0300_0101);
    rdchk(8'h18, 32'h1234, "sample1");
    rdchk(8'h18, 32'h5678, "sample2");
    wr(8'h20, 32'h2);
    wr(8'h00, 32'h1);
    wait_load;
    chk("first", 32'h1234, {16'h0, ch0_word});
    wait_play(1'b0);
    rdchk(8'h1c, 32'h0002_0002, "pos_end");
    chk("hold", 32'h5678, {16'h0, dac_out[15:0]});
    // interval of 64 ticks against a 32 tick segment leaves a gap from tick 32
    wr(8'h10, 32'h40);
    wr(8'h00, 32'h09);
    repeat (4200) @(posedge clk);
    rdchk(8'h1c, 32'h0001_0002, "pos_gap");
    chk("gap_out", 32'h5678, {16'h0, dac_out[15:0]});
    chk("gap_play", 32'h1, {31'h0, play_active});
    wr(8'h00, 32'h2);
    wait_play(1'b0);
    wr(8'h00, 32'h1);
    wait_play(1'b1);
    wr(8'h0c, 32'h10);
    wait_play(1'b0);
    wr(8'h00, 32'h1);
    wait_play(1'b1);
    wb(8'h18, 1'b0, 32'h0);
    wait_play(1'b0);
    wr(8'h00, 32'h1);
    wait_load;
    wr(8'h00, 32'h4);
    @(posedge clk);
    chk("stop", 32'h0, {31'h0, play_active});
    chk("zeroed", 32'h0, dac_out[31:0]);
    rdchk(8'h08, 32'h2, "points");
    wr(8'h14, 32'h0300_0101);
    rdchk(8'h18, 32'h0, "cleared");
    finish_test;
  end

  // hang guard sized well past the longest expected run
  initial begin
    #(40 * 60000);
    err_total++;
    finish_test;
  end
endmodule : arb_waveform_playback_tb
